// ===== verilog/phy_status_summary.v
// Purpose: status summary register with the mirror registers that clear it
// Assumes: APB slave with zero wait states, status pins asynchronous to mclk
// Notes: summary is read-only; mirrored bits clear via reads of other registers
// Function
// - bits 15 and 7 ignore writes and always read as zero.
// - bit 14 reads one when the pairs are swapped, zero when normal.
// - bit 14 follows enable and force settings and tracks the algorithm live.
// - bit 13 latches a receive error until the receive error counter is read.
// - bit 12 mirrors polarity bit 4 and clears only on a 10 Mb/s status read.
// - bit 11 latches a false carrier until the false carrier counter is read.
// - bit 10 is latched-low signal detect, qualified by lock when enabled.
// - bit 9 is the latched-low descrambler lock.
// - bit 8 mirrors page received and clears on a negotiation expansion read.
// - bit 6 sets on partner remote fault and clears on basic status read or reset.
// - bit 0 mirrors link status and is not cleared by a summary read.
// - bit 2 is full duplex and bit 1 is 10 Mb/s, shown only with a valid link.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "phy_status_consts.vh"
module phy_status_summary (
	input wire mclk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire swapState,
	input wire rxErrorEvt,
	input wire polarityInv,
	input wire falseCarrierEvt,
	input wire rawSignalDetect,
	input wire descramblerLock,
	input wire pageRecvEvt,
	input wire remoteFaultEvt,
	input wire fullDuplex,
	input wire speed10,
	input wire linkUp,
	output reg irq
);
	// synchronised pin levels
	wire swapS; // pair swap as the algorithm sees it
	wire rxErrS;
	wire polS;
	wire fcarS;
	wire rawSdS;
	wire lockS;
	wire pageS;
	wire rfaultS;
	wire dupS;
	wire spdS;
	wire linkS; // also gates duplex and speed
	sync_bit uSwap (.mclk(mclk), .rst_n(rst_n), .din(swapState), .dout(swapS));
	sync_bit uRxe (.mclk(mclk), .rst_n(rst_n), .din(rxErrorEvt), .dout(rxErrS));
	sync_bit uPol (.mclk(mclk), .rst_n(rst_n), .din(polarityInv), .dout(polS));
	sync_bit uFc (.mclk(mclk), .rst_n(rst_n), .din(falseCarrierEvt), .dout(fcarS));
	sync_bit uSd (.mclk(mclk), .rst_n(rst_n), .din(rawSignalDetect), .dout(rawSdS));
	sync_bit uLk (.mclk(mclk), .rst_n(rst_n), .din(descramblerLock), .dout(lockS));
	sync_bit uPg (.mclk(mclk), .rst_n(rst_n), .din(pageRecvEvt), .dout(pageS));
	sync_bit uRf (.mclk(mclk), .rst_n(rst_n), .din(remoteFaultEvt), .dout(rfaultS));
	sync_bit uDx (.mclk(mclk), .rst_n(rst_n), .din(fullDuplex), .dout(dupS));
	sync_bit uSp (.mclk(mclk), .rst_n(rst_n), .din(speed10), .dout(spdS));
	sync_bit uLn (.mclk(mclk), .rst_n(rst_n), .din(linkUp), .dout(linkS));

	// event edges: a level pin counts once per rising edge
	reg rxErrD_reg;
	reg fcarD_reg;
	reg pageD_reg;
	reg rfaultD_reg;
	wire rxErrPulse = rxErrS & ~rxErrD_reg;
	wire fcarPulse = fcarS & ~fcarD_reg;
	wire pagePulse = pageS & ~pageD_reg;
	wire rfaultPulse = rfaultS & ~rfaultD_reg;

	// bus strobes; reads take effect in the access cycle only
	wire access = psel & penable;
	wire rdAcc = access & ~pwrite;
	wire wrAcc = access & pwrite;
	wire rdRxCnt = rdAcc & (paddr == `OFS_RXERR_CNT);
	wire rdFcCnt = rdAcc & (paddr == `OFS_FCAR_CNT);
	wire rdTen = rdAcc & (paddr == `OFS_TENSTAT);
	wire rdNeg = rdAcc & (paddr == `OFS_NEGEXP);
	wire rdBasic = rdAcc & (paddr == `OFS_BASICSTAT);
	wire rdSum = rdAcc & (paddr == `OFS_SUMMARY);

	// control settings
	reg [`CTRL_W-1:0] ctrl_reg;
	// sticky flags, cleared only by reads of the registers that own them
	reg rxErrLatch_reg;
	reg fcarLatch_reg;
	reg polLatch_reg;
	reg pageLatch_reg;
	reg rfault_reg;
	// latched-low pair; zero until a summary read re-arms them
	reg sigDetLow_reg;
	reg lockLow_reg;
	// event counters
	reg [`CNT_W-1:0] rxCnt_reg;
	reg [`CNT_W-1:0] fcCnt_reg;
	// interrupt status and mask share one layout
	reg [`IRQ_W-1:0] irqStat_reg;
	reg [`IRQ_W-1:0] irqMask_reg;
	// read path working values, combinational
	reg [15:0] summary;
	reg [31:0] rdata_next;
	reg slverr_next;

	// qualified signal detect: raw, or raw and lock when qualify is set
	// qualify select
	wire qualSd = ctrl_reg[`CTRL_QUAL] ? (rawSdS & lockS) : rawSdS;

	// crossover as chosen: forced gives swapped, disabled and unforced gives normal
	// enable and force
	wire xover = ctrl_reg[`CTRL_XFORCE] ? 1'h1 : (ctrl_reg[`CTRL_XEN] ? swapS : 1'h0);

	// summary assembly; summary reads never clear any bit
	always @* begin
		summary = `SUM_RESET;
		summary[`BIT_XOVER] = xover;
		summary[`BIT_RXERR] = rxErrLatch_reg;
		summary[`BIT_POL] = polLatch_reg;
		summary[`BIT_FCAR] = fcarLatch_reg;
		summary[`BIT_SIGDET] = sigDetLow_reg;
		summary[`BIT_LOCK] = lockLow_reg;
		summary[`BIT_PAGE] = pageLatch_reg;
		summary[`BIT_RFAULT] = rfault_reg;
		summary[`BIT_DUPLEX] = dupS & linkS;
		summary[`BIT_SPEED10] = spdS & linkS;
		summary[`BIT_LINK] = linkS;
		// bits 15 and 7 stay at zero from the default
	end

	// edge history for the event pins; reset low matches their idle level,
	// so no false event follows reset
	always @(posedge mclk) begin
		if (!rst_n) begin
			rxErrD_reg <= 1'h0;
			fcarD_reg <= 1'h0;
			pageD_reg <= 1'h0;
			rfaultD_reg <= 1'h0;
		end else begin
			rxErrD_reg <= rxErrS;
			fcarD_reg <= fcarS;
			pageD_reg <= pageS;
			rfaultD_reg <= rfaultS;
		end
	end

	// sticky flags: set beats clear so an event in the clearing cycle survives
	// at the cost of one extra read after a burst of events
	always @(posedge mclk) begin
		if (!rst_n) begin
			rxErrLatch_reg <= 1'h0;
			fcarLatch_reg <= 1'h0;
			pageLatch_reg <= 1'h0;
			rfault_reg <= 1'h0;
		end else begin
			if (rxErrPulse)
				rxErrLatch_reg <= 1'h1;
			else if (rdRxCnt)
				rxErrLatch_reg <= 1'h0;
			if (fcarPulse)
				fcarLatch_reg <= 1'h1;
			else if (rdFcCnt)
				fcarLatch_reg <= 1'h0;
			// page flag cleared by expansion read
			if (pagePulse)
				pageLatch_reg <= 1'h1;
			else if (rdNeg)
				pageLatch_reg <= 1'h0;
			// remote fault cleared by basic status read
			if (rfaultPulse)
				rfault_reg <= 1'h1;
			else if (rdBasic)
				rfault_reg <= 1'h0;
		end
	end

	// polarity is a level, not an edge: a read while the pin is still
	// inverted cannot drop it
	always @(posedge mclk) begin
		if (!rst_n) begin
			polLatch_reg <= 1'h0;
		end else begin
			// polarity held until 10 Mb/s status read
			if (polS)
				polLatch_reg <= 1'h1;
			else if (rdTen)
				polLatch_reg <= 1'h0;
		end
	end

	// latched-low pair: a drop wins, a summary read re-arms to the current level;
	// reset leaves both low so the first read after reset shows zero
	always @(posedge mclk) begin
		if (!rst_n) begin
			sigDetLow_reg <= 1'h0;
			lockLow_reg <= 1'h0;
		end else begin
			if (!qualSd)
				sigDetLow_reg <= 1'h0;
			else if (rdSum)
				sigDetLow_reg <= 1'h1;
			if (!lockS)
				lockLow_reg <= 1'h0;
			else if (rdSum)
				lockLow_reg <= 1'h1;
		end
	end

	// counters stick at max and clear on read; an event in the read cycle
	// restarts the count at one, even from max, so it is never lost
	always @(posedge mclk) begin
		if (!rst_n) begin
			rxCnt_reg <= `CNT_ZERO;
			fcCnt_reg <= `CNT_ZERO;
		end else begin
			if (rxErrPulse && rdRxCnt)
				rxCnt_reg <= `CNT_ONE;
			else if (rdRxCnt)
				rxCnt_reg <= `CNT_ZERO;
			else if (rxErrPulse && rxCnt_reg != `CNT_MAX)
				rxCnt_reg <= rxCnt_reg + `CNT_ONE;
			if (fcarPulse && rdFcCnt)
				fcCnt_reg <= `CNT_ONE;
			else if (rdFcCnt)
				fcCnt_reg <= `CNT_ZERO;
			else if (fcarPulse && fcCnt_reg != `CNT_MAX)
				fcCnt_reg <= fcCnt_reg + `CNT_ONE;
		end
	end

	// sticky interrupt status, write one to clear, set wins
	wire [`IRQ_W-1:0] irqEvt = {rfaultPulse, pagePulse, fcarPulse, rxErrPulse};
	wire wrStat = wrAcc & (paddr == `OFS_IRQ_STAT);
	wire wrMask = wrAcc & (paddr == `OFS_IRQ_MASK);
	wire wrCtrl = wrAcc & (paddr == `OFS_CTRL);
	wire [`IRQ_W-1:0] irqClr = wrStat ? pwdata[`IRQ_W-1:0] : {`IRQ_W{1'h0}};
	always @(posedge mclk) begin
		if (!rst_n) begin
			irqStat_reg <= {`IRQ_W{1'h0}};
		end else begin
			irqStat_reg <= irqEvt | (irqStat_reg & ~irqClr);
		end
	end

	// writable settings; every other write address except the status clear leaves state alone
	always @(posedge mclk) begin
		if (!rst_n) begin
			irqMask_reg <= {`IRQ_W{1'h0}};
			ctrl_reg <= `CTRL_RESET;
		end else begin
			if (wrMask)
				irqMask_reg <= pwdata[`IRQ_W-1:0];
			if (wrCtrl)
				ctrl_reg <= pwdata[`CTRL_W-1:0];
		end
	end

	// level interrupt, one cycle behind the status it reflects
	always @(posedge mclk) begin
		if (!rst_n) begin
			irq <= 1'h0;
		end else begin
			irq <= |(irqStat_reg & irqMask_reg);
		end
	end

	// read mux; unmapped addresses answer zero with pslverr
	// summary writes fall through with no effect
	always @* begin
		rdata_next = 32'h0000_0000;
		slverr_next = 1'b0;
		case (paddr)
			`OFS_SUMMARY: rdata_next = {16'h0000, summary};
			`OFS_RXERR_CNT: rdata_next = {24'h00_0000, rxCnt_reg};
			`OFS_FCAR_CNT: rdata_next = {24'h00_0000, fcCnt_reg};
			`OFS_TENSTAT: rdata_next[`TENSTAT_POL] = polLatch_reg;
			`OFS_NEGEXP: rdata_next[`NEGEXP_PAGE] = pageLatch_reg;
			`OFS_BASICSTAT: rdata_next = 32'h0000_0000;
			`OFS_CTRL: rdata_next = {29'h0000_0000, ctrl_reg};
			`OFS_IRQ_STAT: rdata_next = {28'h000_0000, irqStat_reg};
			`OFS_IRQ_MASK: rdata_next = {28'h000_0000, irqMask_reg};
			default: slverr_next = 1'b1;
		endcase
	end

	// answer registered in the setup cycle so the access completes at once;
	// the trade: read data show state one edge before the clearing edge
	wire setupCyc = psel & ~penable;
	always @(posedge mclk) begin
		if (!rst_n) begin
			prdata <= `DATA_ZERO;
			pready <= 1'h0;
			pslverr <= 1'h0;
		end else begin
			pready <= setupCyc;
			prdata <= (setupCyc & ~pwrite) ? rdata_next : `DATA_ZERO;
			pslverr <= setupCyc & slverr_next;
		end
	end
endmodule

// ===== verilog/phy_status_consts.vh
// Purpose: constants for the status summary block
// Assumes: APB, 32-bit data, one word per register
// Notes: summary offset 0x10 is a byte address (multiple of four)
`ifndef PHY_STATUS_CONSTS_VH
`define PHY_STATUS_CONSTS_VH
`define ADDR_W 8
`define OFS_SUMMARY 8'h10
`define OFS_RXERR_CNT 8'h54
`define OFS_FCAR_CNT 8'h50
`define OFS_TENSTAT 8'h28
`define OFS_NEGEXP 8'h18
`define OFS_BASICSTAT 8'h04
`define OFS_CTRL 8'h40
`define OFS_IRQ_STAT 8'h44
`define OFS_IRQ_MASK 8'h48
`define SUM_RESET 16'h0000
`define CNT_MAX 8'hFF
`define CNT_ZERO 8'h00
`define CNT_ONE 8'h01
`define CNT_W 8
`define CTRL_W 3
`define CTRL_RESET 3'h0
`define DATA_ZERO 32'h0000_0000
`define BIT_XOVER 14
`define BIT_RXERR 13
`define BIT_POL 12
`define BIT_FCAR 11
`define BIT_SIGDET 10
`define BIT_LOCK 9
`define BIT_PAGE 8
`define BIT_RFAULT 6
`define BIT_DUPLEX 2
`define BIT_SPEED10 1
`define BIT_LINK 0
`define CTRL_QUAL 0
`define CTRL_XEN 1
`define CTRL_XFORCE 2
`define NEGEXP_PAGE 1
`define TENSTAT_POL 4
`define IRQ_W 4
`define IRQ_RXERR 0
`define IRQ_FCAR 1
`define IRQ_PAGE 2
`define IRQ_RFAULT 3
`endif

// ===== verilog/sync_bit.v
// Purpose: two-flop synchroniser for one pin level
// Assumes: mclk domain, synchronous active-low reset
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module sync_bit (
	input wire mclk,
	input wire rst_n,
	input wire din,
	output reg dout
);
	reg meta_reg;
	// two stages, nothing reads the first but the second
	always @(posedge mclk) begin
		if (!rst_n) begin
			meta_reg <= 1'h0;
			dout <= 1'h0;
		end else begin
			meta_reg <= din;
			dout <= meta_reg;
		end
	end
endmodule

// ===== dv/phy_status_summary_props.sv
// Purpose: port checks for the status summary block
// Assumes: one clock, zero wait states
// Notes: link mirror judged only after a quiet spell on the pin
`timescale 1ns/1ps
`include "phy_status_consts.vh"
module phy_status_summary_props (
	input wire mclk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire linkUp,
	input wire irq
);
	logic prevLink_reg;
	logic [3:0] quietCnt_reg;
	wire sumRead = pready && psel && !pwrite && paddr == `OFS_SUMMARY;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// cycles since the link pin last moved; sync flops need a few
	always @(posedge mclk) begin
		prevLink_reg <= linkUp;
		if (!rst_n || linkUp != prevLink_reg)
			quietCnt_reg <= 4'h0;
		else if (quietCnt_reg != 4'hF)
			quietCnt_reg <= quietCnt_reg + 4'h1;
	end
	a_zero_wait: assert property (psel && penable |-> pready)
		else $error("access cycle without pready");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	a_err_data_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
		else $error("error answer carries data");
	a_unmapped_err: assert property (pready && paddr > `OFS_RXERR_CNT |-> pslverr)
		else $error("unmapped address not flagged");
	a_reserved_zero: assert property (sumRead |-> prdata[15] == 1'h0 && prdata[7] == 1'h0)
		else $error("reserved summary bit set");
	a_duplex_link: assert property (sumRead && !prdata[0] |-> prdata[2:1] == 2'h0)
		else $error("duplex or speed shown without link");
	a_link_mirror: assert property (sumRead && quietCnt_reg > 4'h7 |-> prdata[0] == linkUp)
		else $error("link bit differs from settled pin");
	a_reset_quiet: assert property (disable iff (1'h0) !rst_n |=> !pready && !irq && !pslverr)
		else $error("output active after reset edge");
endmodule
bind phy_status_summary phy_status_summary_props phy_status_summary_props_i (.mclk(mclk),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .linkUp(linkUp), .irq(irq));

// ===== dv/apb_host_model.sv
// Purpose: management host issuing apb transfers
// Assumes: pready sampled on rising mclk
// Notes: one idle cycle between transfers
`timescale 1ns/1ps
module apb_host_model (
	input wire mclk,
	input wire pready,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	// quiet bus before the first request
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// setup, then access held until pready is seen
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do @(posedge mclk); while (!(psel && penable && pready));
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
endmodule

// ===== dv/phy_status_summary_tb_top.sv
// Purpose: self-checking bench for the status summary register
// Assumes: pins reach the register within six cycles
// Notes: reads queue expectations; a monitor compares at pready
`timescale 1ns/1ps
`include "phy_status_consts.vh"
module phy_status_summary_tb_top;
	logic mclk, rst_n, pready, pslverr, irq, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, seed;
	logic [3:0] evt;
	logic swapState, polarityInv, rawSignalDetect, descramblerLock, fullDuplex, speed10, linkUp;
	logic [32:0] expQ [$];
	int comparisons, mismatches, cycles;
	logic [7:0] clrAddr [4] = '{`OFS_RXERR_CNT, `OFS_FCAR_CNT, `OFS_NEGEXP, `OFS_BASICSTAT};
	logic [32:0] clrVal [4] = '{33'h0_0000_0001, 33'h0_0000_0001, 33'h0_0000_0002, 33'h0_0000_0000};
	int bitPos [4] = '{`BIT_RXERR, `BIT_FCAR, `BIT_PAGE, `BIT_RFAULT};
	apb_host_model apb_host_model_i (.mclk(mclk), .pready(pready), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	phy_status_summary phy_status_summary_i (.mclk(mclk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .swapState(swapState), .rxErrorEvt(evt[0]),
		.polarityInv(polarityInv), .falseCarrierEvt(evt[1]), .rawSignalDetect(rawSignalDetect),
		.descramblerLock(descramblerLock), .pageRecvEvt(evt[2]), .remoteFaultEvt(evt[3]),
		.fullDuplex(fullDuplex), .speed10(speed10), .linkUp(linkUp), .irq(irq));
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string what, input logic [32:0] e, input logic [32:0] s);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		expQ.push_back(e);
		apb_host_model_i.xfer(1'h0, a, 32'h0000_0000);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb_host_model_i.xfer(1'h1, a, d);
	endtask
	task automatic sum(input logic [15:0] v);
		rd(`OFS_SUMMARY, {17'h0_0000, v});
	endtask
	task automatic settle();
		repeat (6) @(posedge mclk);
	endtask
	// an event is a short high level on its pin
	task automatic pulse(input int k);
		@(posedge mclk);
		evt[k] <= 1'h1;
		repeat (3) @(posedge mclk);
		evt[k] <= 1'h0;
		settle();
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// oldest expectation meets each read answer
	always @(posedge mclk) begin
		if (psel && penable && pready && !pwrite)
			chk("prdata", expQ.pop_front(), {pslverr, prdata});
	end
	// a hang ends well past the expected run
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 8000) begin
			mismatches++;
			report_and_stop();
		end
	end
	initial begin
		seed = 32'h0000_b2ff;
		rst_n = 1'h0;
		evt = 4'h0;
		{swapState, polarityInv, rawSignalDetect, descramblerLock} = 4'h0;
		{fullDuplex, speed10, linkUp} = 3'h0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'h1;
		sum(16'h0000);
		wr(`OFS_SUMMARY, xs());
		sum(16'h0000);
		rd({2'h3, seed[5:2], 2'h0}, 33'h1_0000_0000);
		$display("test access done");
		// crossover from force, enable and pin
		for (int i = 0; i < 8; i++) begin
			wr(`OFS_CTRL, {29'h0000_0000, i[2:1], 1'h0});
			swapState <= i[0];
			settle();
			sum({1'h0, i[2] | (i[1] & i[0]), 14'h0000});
		end
		wr(`OFS_CTRL, 32'h0000_0000);
		$display("test crossover done");
		repeat (6) begin
			void'(xs());
			{linkUp, speed10, fullDuplex} <= seed[2:0];
			settle();
			sum({13'h0000, seed[0] & seed[2], seed[1] & seed[2], seed[2]});
			sum({13'h0000, seed[0] & seed[2], seed[1] & seed[2], seed[2]});
		end
		linkUp <= 1'h0;
		$display("test link done");
		wr(`OFS_IRQ_MASK, 32'h0000_000F);
		rd(`OFS_IRQ_MASK, 33'h0_0000_000F);
		// latch survives summary read, clears elsewhere
		for (int k = 0; k < 4; k++) begin
			pulse(k);
			sum(16'h0001 << bitPos[k]);
			sum(16'h0001 << bitPos[k]);
			chk("irq", 33'h0_0000_0001, irq);
			rd(clrAddr[k], clrVal[k]);
			sum(16'h0000);
			rd(`OFS_IRQ_STAT, 33'h0_0000_0001 << k);
			wr(`OFS_IRQ_STAT, 32'h0000_0001 << k);
			settle();
			chk("irq", 33'h0_0000_0000, irq);
		end
		// masked event stays quiet until unmasked
		wr(`OFS_IRQ_MASK, 32'h0000_0000);
		pulse(1);
		chk("irq", 33'h0_0000_0000, irq);
		wr(`OFS_IRQ_MASK, 32'h0000_0002);
		settle();
		chk("irq", 33'h0_0000_0001, irq);
		wr(`OFS_IRQ_STAT, 32'h0000_0002);
		rd(`OFS_FCAR_CNT, 33'h0_0000_0001);
		chk("irq", 33'h0_0000_0000, irq);
		$display("test events done");
		// polarity kept until the 10 Mb status read
		polarityInv <= 1'h1;
		settle();
		sum(16'h1000);
		polarityInv <= 1'h0;
		settle();
		sum(16'h1000);
		rd(`OFS_TENSTAT, 33'h0_0000_0010);
		sum(16'h0000);
		// latched-low detect and lock, re-armed by reads
		wr(`OFS_CTRL, 32'h0000_0001);
		rd(`OFS_CTRL, 33'h0_0000_0001);
		{rawSignalDetect, descramblerLock} <= 2'h3;
		settle();
		sum(16'h0000);
		sum(16'h0600);
		for (int q = 1; q >= 0; q--) begin
			wr(`OFS_CTRL, q);
			descramblerLock <= 1'h0;
			settle();
			descramblerLock <= 1'h1;
			settle();
			sum(q ? 16'h0000 : 16'h0400);
			sum(16'h0600);
		end
		$display("test detect done");
		repeat (4) @(posedge mclk);
		report_and_stop();
	end
endmodule
